// File: hdl/dcc_top.sv
// Register core and APB slave of the dual comparator control block
// Function
// - Two identical channels; only channel a drives a reset source path
// - Each channel gives a clocked latched output and a raw unclocked output
// - A disabled channel holds its pin-bound outputs low
// - Rising and falling edges set sticky flags kept until software writes zero
// - Edge requests raised when a rise or fall flag is set together with its enable, rise enable bit 5 or fall enable bit 4
// - Control bit 6 reads the current comparator result, read only
// - Control bit 7 turns the channel on or off, reset 0
// - Enabled channel with low output requests oscillator wake-up
// - Control bits 3..2 carry positive hysteresis code to the analog core
// - Control bits 1..0 carry negative hysteresis code to the analog core
// - Mode bits 1..0 select response mode, register resets to 0x02
// - Mux bits 7..4 select negative input pin, reset all ones
// - Mux bits 3..0 select positive input pin, codes 11xx reserved
// - Mode bit 7 and unused mode bits read zero and ignore writes
// - Channel b mode register at index 0x9c, same layout as channel a
// - Channel b control register at index 0x9a, same layout and reset
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_top
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      cmp_result_a,
    input  wire logic                      cmp_result_b,
    output logic                           chan_on,
    output logic                           chan_b_on,
    output logic                           raw_out_a,
    output logic                           raw_out_b,
    output logic                           latched_out_a,
    output logic                           latched_out_b,
    output logic                           reset_src_a,
    output dcc_pkg::dcc_hyst_type          pos_hyst_code,
    output dcc_pkg::dcc_hyst_type          neg_hyst_code,
    output dcc_pkg::dcc_hyst_type          pos_hyst_code_b,
    output dcc_pkg::dcc_hyst_type          neg_hyst_code_b,
    output dcc_pkg::dcc_resp_type          response_mode_sel,
    output dcc_pkg::dcc_resp_type          response_mode_sel_b,
    output dcc_pkg::dcc_pin_sel_type       pos_pin_sel_a,
    output dcc_pkg::dcc_pin_sel_type       neg_pin_sel_a,
    output dcc_pkg::dcc_pin_sel_type       pos_pin_sel_b,
    output dcc_pkg::dcc_pin_sel_type       neg_pin_sel_b,
    output logic                           edge_irq_a,
    output logic                           edge_irq_b,
    output logic                           wake_req,
    output logic                           irq
);
    import dcc_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    dcc_ctrl_type ctrl_reg   [2];
    dcc_ctrl_type ctrl_next  [2];
    dcc_mode_type mode_reg   [2];
    dcc_mode_type mode_next  [2];
    logic [7:0]   mux_reg    [2];
    logic [7:0]   mux_next   [2];
    logic [3:0]   stat_reg;
    logic [3:0]   stat_next;
    logic [3:0]   mask_reg;
    logic [3:0]   mask_next;
    logic [31:0]  rdata_reg;
    logic [31:0]  rdata_next;

    logic [9:0]   widx;
    logic         setup_ph;
    logic         access_ph;
    logic         wr_en;
    logic         hit_ctrl   [2];
    logic         hit_mode   [2];
    logic         hit_mux    [2];
    logic         hit_stat;
    logic         hit_mask;
    logic         mapped;
    logic         rise_evt   [2];
    logic         fall_evt   [2];
    logic         latched    [2];
    logic [3:0]   stat_evt;
    logic [7:0]   wbyte;

    dcc_chan_if   chan_a_if ();
    dcc_chan_if   chan_b_if ();

    // ****************************************************************
    // APB decode
    // ****************************************************************

    // Word index of the access; registers sit on aligned words
    assign widx      = paddr[11:2];
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wbyte     = pwdata[7:0];

    // Register hits, channel a at slot 0 and channel b at slot 1
    always_comb
    begin
        hit_ctrl[0] = (widx == 10'(`DCC_IDX_CTRL_A));
        hit_ctrl[1] = (widx == 10'(`DCC_IDX_CTRL_B));
        hit_mode[0] = (widx == 10'(`DCC_IDX_MODE_A));
        hit_mode[1] = (widx == 10'(`DCC_IDX_MODE_B));
        hit_mux[0]  = (widx == 10'(`DCC_IDX_MUX_A));
        hit_mux[1]  = (widx == 10'(`DCC_IDX_MUX_B));
        hit_stat    = (widx == 10'(`DCC_IDX_IRQ_STAT));
        hit_mask    = (widx == 10'(`DCC_IDX_IRQ_MASK));
        mapped      = hit_ctrl[0] | hit_ctrl[1] | hit_mode[0] | hit_mode[1]
                    | hit_mux[0] | hit_mux[1] | hit_stat | hit_mask;
    end

    // Zero wait states; the low byte lane carries all register data
    assign pready  = access_ph;
    assign pslverr = access_ph & ~mapped;
    assign wr_en   = access_ph & pwrite & pstrb[0] & mapped;

    // ****************************************************************
    // Channels
    // ****************************************************************

    // Channel a
    assign chan_a_if.chan_on = ctrl_reg[0].on;
    assign chan_a_if.cmp_in  = cmp_result_a;

    dcc_chan u_chan_a
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (chan_a_if)
    );

    // Channel b, identical control behaviour
    assign chan_b_if.chan_on = ctrl_reg[1].on;
    assign chan_b_if.cmp_in  = cmp_result_b;

    dcc_chan u_chan_b
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (chan_b_if)
    );

    // Channel events gathered into arrays for the register loop
    always_comb
    begin
        rise_evt[0] = chan_a_if.rise_evt;
        fall_evt[0] = chan_a_if.fall_evt;
        latched[0]  = chan_a_if.latched;
        rise_evt[1] = chan_b_if.rise_evt;
        fall_evt[1] = chan_b_if.fall_evt;
        latched[1]  = chan_b_if.latched;
    end

    // ****************************************************************
    // Channel registers
    // ****************************************************************

    // Software writes first, then hardware sets so an edge is never lost
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            ctrl_next[i] = ctrl_reg[i];
            mode_next[i] = mode_reg[i];
            mux_next[i]  = mux_reg[i];
            if (wr_en && hit_ctrl[i])
            begin
                ctrl_next[i].on        = wbyte[`DCC_CTRL_EN_BIT];
                ctrl_next[i].rise_seen = wbyte[`DCC_CTRL_RIF_BIT];
                ctrl_next[i].fall_seen = wbyte[`DCC_CTRL_FIF_BIT];
                ctrl_next[i].pos_hyst  =
                    dcc_hyst_type'(wbyte[`DCC_CTRL_HYP_LSB +: 2]);
                ctrl_next[i].neg_hyst  =
                    dcc_hyst_type'(wbyte[`DCC_CTRL_HYN_LSB +: 2]);
            end
            if (wr_en && hit_mode[i])
            begin
                mode_next[i].rise_irq_on = wbyte[`DCC_MODE_RIE_BIT];
                mode_next[i].fall_irq_on = wbyte[`DCC_MODE_FIE_BIT];
                mode_next[i].mode        =
                    dcc_resp_type'(wbyte[`DCC_MODE_MD_LSB +: 2]);
            end
            if (wr_en && hit_mux[i])
            begin
                mux_next[i] = wbyte;
            end
            if (rise_evt[i])
            begin
                ctrl_next[i].rise_seen = 1'b1;
            end
            if (fall_evt[i])
            begin
                ctrl_next[i].fall_seen = 1'b1;
            end
        end
    end

    // Register the channel state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ctrl_reg[i] <= dcc_ctrl_type'({1'b0, 1'b0, 1'b0, 4'h0});
                mode_reg[i] <= dcc_mode_type'({1'b0, 1'b0,
                                               2'(`DCC_MODE_RST)});
                mux_reg[i]  <= `DCC_MUX_RST;
            end
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                ctrl_reg[i] <= ctrl_next[i];
                mode_reg[i] <= mode_next[i];
                mux_reg[i]  <= mux_next[i];
            end
        end
    end

    // ****************************************************************
    // Interrupt status and mask
    // ****************************************************************

    // An edge counts as an interrupt event only when its enable is set
    always_comb
    begin
        stat_evt                  = 4'h0;
        stat_evt[`DCC_IRQ_RISE_A] = rise_evt[0] & mode_reg[0].rise_irq_on;
        stat_evt[`DCC_IRQ_FALL_A] = fall_evt[0] & mode_reg[0].fall_irq_on;
        stat_evt[`DCC_IRQ_RISE_B] = rise_evt[1] & mode_reg[1].rise_irq_on;
        stat_evt[`DCC_IRQ_FALL_B] = fall_evt[1] & mode_reg[1].fall_irq_on;
    end

    // Write one to clear; a new event in the same cycle wins
    always_comb
    begin
        stat_next = stat_reg;
        mask_next = mask_reg;
        if (wr_en && hit_stat)
        begin
            stat_next = stat_reg & ~wbyte[3:0];
        end
        if (wr_en && hit_mask)
        begin
            mask_next = wbyte[3:0];
        end
        stat_next = stat_next | stat_evt;
    end

    // Register status and mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_reg <= `DCC_IRQ_RST;
            mask_reg <= `DCC_IRQ_RST;
        end
        else
        begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(stat_reg & mask_reg);

    // ****************************************************************
    // Read data
    // ****************************************************************

    // Read word captured in the setup cycle, so prdata comes from a flop
    always_comb
    begin
        rdata_next = rdata_reg;
        if (setup_ph)
        begin
            rdata_next = 32'h0;
            for (int i = 0; i < 2; i++)
            begin
                if (hit_ctrl[i])
                begin
                    rdata_next[`DCC_CTRL_EN_BIT]          = ctrl_reg[i].on;
                    rdata_next[`DCC_CTRL_OUT_BIT]         = latched[i];
                    rdata_next[`DCC_CTRL_RIF_BIT]         = ctrl_reg[i].rise_seen;
                    rdata_next[`DCC_CTRL_FIF_BIT]         = ctrl_reg[i].fall_seen;
                    rdata_next[`DCC_CTRL_HYP_LSB +: 2]    = ctrl_reg[i].pos_hyst;
                    rdata_next[`DCC_CTRL_HYN_LSB +: 2]    = ctrl_reg[i].neg_hyst;
                end
                if (hit_mode[i])
                begin
                    // Bits 7, 6, 3 and 2 stay zero
                    rdata_next[`DCC_MODE_RIE_BIT]         = mode_reg[i].rise_irq_on;
                    rdata_next[`DCC_MODE_FIE_BIT]         = mode_reg[i].fall_irq_on;
                    rdata_next[`DCC_MODE_MD_LSB +: 2]     = mode_reg[i].mode;
                end
                if (hit_mux[i])
                begin
                    rdata_next[7:0] = mux_reg[i];
                end
            end
            if (hit_stat)
            begin
                rdata_next[3:0] = stat_reg;
            end
            if (hit_mask)
            begin
                rdata_next[3:0] = mask_reg;
            end
        end
    end

    // Register read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_reg <= 32'h0;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign prdata = rdata_reg;

    // ****************************************************************
    // Outputs to the analog core, crossbar and system
    // ****************************************************************

    // Enables and pin-bound outputs
    assign chan_on         = ctrl_reg[0].on;
    assign chan_b_on       = ctrl_reg[1].on;
    assign raw_out_a       = chan_a_if.raw_out;
    assign raw_out_b       = chan_b_if.raw_out;
    assign latched_out_a   = chan_a_if.latched;
    assign latched_out_b   = chan_b_if.latched;

    // Reset source path exists for channel a only
    assign reset_src_a     = chan_a_if.latched;

    // Hysteresis codes straight from the control registers
    assign pos_hyst_code   = ctrl_reg[0].pos_hyst;
    assign neg_hyst_code   = ctrl_reg[0].neg_hyst;
    assign pos_hyst_code_b = ctrl_reg[1].pos_hyst;
    assign neg_hyst_code_b = ctrl_reg[1].neg_hyst;

    // Response mode per channel
    assign response_mode_sel   = mode_reg[0].mode;
    assign response_mode_sel_b = mode_reg[1].mode;

    // Input multiplexer selects; reserved codes pass through unchanged
    assign neg_pin_sel_a = mux_reg[0][`DCC_MUX_NEG_LSB +: 4];
    assign pos_pin_sel_a = mux_reg[0][`DCC_MUX_POS_LSB +: 4];
    assign neg_pin_sel_b = mux_reg[1][`DCC_MUX_NEG_LSB +: 4];
    assign pos_pin_sel_b = mux_reg[1][`DCC_MUX_POS_LSB +: 4];

    // Per-channel edge requests from flags and their enables
    assign edge_irq_a = (ctrl_reg[0].rise_seen & mode_reg[0].rise_irq_on)
                      | (ctrl_reg[0].fall_seen & mode_reg[0].fall_irq_on);
    assign edge_irq_b = (ctrl_reg[1].rise_seen & mode_reg[1].rise_irq_on)
                      | (ctrl_reg[1].fall_seen & mode_reg[1].fall_irq_on);

    // Oscillator wake, works without the clock
    assign wake_req = chan_a_if.wake | chan_b_if.wake;
endmodule

// File: hdl/dcc_consts.svh
// Register indices, field positions and reset values of the comparator control block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DCC_IDX_CTRL_B    8'h9a
`define DCC_IDX_CTRL_A    8'h9b
`define DCC_IDX_MODE_B    8'h9c
`define DCC_IDX_MODE_A    8'h9d
`define DCC_IDX_MUX_B     8'h9e
`define DCC_IDX_MUX_A     8'h9f
`define DCC_IDX_IRQ_STAT  8'ha0
`define DCC_IDX_IRQ_MASK  8'ha1

// ****************************************************************
// Field positions
// ****************************************************************
`define DCC_CTRL_EN_BIT   7
`define DCC_CTRL_OUT_BIT  6
`define DCC_CTRL_RIF_BIT  5
`define DCC_CTRL_FIF_BIT  4
`define DCC_CTRL_HYP_LSB  2
`define DCC_CTRL_HYN_LSB  0
`define DCC_MODE_RIE_BIT  5
`define DCC_MODE_FIE_BIT  4
`define DCC_MODE_MD_LSB   0
`define DCC_MUX_NEG_LSB   4
`define DCC_MUX_POS_LSB   0
`define DCC_IRQ_RISE_A    0
`define DCC_IRQ_FALL_A    1
`define DCC_IRQ_RISE_B    2
`define DCC_IRQ_FALL_B    3

// ****************************************************************
// Reset values
// ****************************************************************
`define DCC_CTRL_RST      8'h00
`define DCC_MODE_RST      8'h02
`define DCC_MUX_RST       8'hff
`define DCC_IRQ_RST       4'h0

`endif

// File: hdl/dcc_pkg.sv
// Types shared by the comparator control block
package dcc_pkg;

    // Hysteresis amount code driven to the analog core
    typedef enum logic [1:0]
    {
        DCC_HYST_OFF  = 2'h0,
        DCC_HYST_5MV  = 2'h1,
        DCC_HYST_10MV = 2'h2,
        DCC_HYST_20MV = 2'h3
    } dcc_hyst_type;

    // Response time against power trade-off
    typedef enum logic [1:0]
    {
        DCC_RESP_FAST = 2'h0,
        DCC_RESP_MID1 = 2'h1,
        DCC_RESP_MID2 = 2'h2,
        DCC_RESP_LOW  = 2'h3
    } dcc_resp_type;

    // Input pin select code; codes 11xx are reserved
    typedef logic [3:0] dcc_pin_sel_type;

    // Stored control fields of one channel
    typedef struct packed
    {
        logic         on;
        logic         rise_seen;
        logic         fall_seen;
        dcc_hyst_type pos_hyst;
        dcc_hyst_type neg_hyst;
    } dcc_ctrl_type;

    // Stored mode fields of one channel
    typedef struct packed
    {
        logic         rise_irq_on;
        logic         fall_irq_on;
        dcc_resp_type mode;
    } dcc_mode_type;

endpackage

// File: hdl/dcc_chan_if.sv
// Signals between the register core and one comparator channel
`timescale 1ns/1ps

interface dcc_chan_if;
    logic chan_on;
    logic cmp_in;
    logic raw_out;
    logic latched;
    logic rise_evt;
    logic fall_evt;
    logic wake;

    modport ctl
    (
        output chan_on,
        output cmp_in,
        input  raw_out,
        input  latched,
        input  rise_evt,
        input  fall_evt,
        input  wake
    );

    modport chan
    (
        input  chan_on,
        input  cmp_in,
        output raw_out,
        output latched,
        output rise_evt,
        output fall_evt,
        output wake
    );
endinterface

// File: hdl/dcc_chan.sv
// One comparator channel: synchroniser, edge detect, gated outputs and wake request
`timescale 1ns/1ps

module dcc_chan
(
    input wire logic pclk,
    input wire logic presetn,
    dcc_chan_if.chan ch
);
    import dcc_pkg::*;

    logic s1_reg;
    logic s2_reg;
    logic prev_reg;
    logic s1_next;
    logic s2_next;
    logic prev_next;

    // Two-stage synchroniser plus one sample of history
    always_comb
    begin
        s1_next   = ch.cmp_in & ch.chan_on;
        s2_next   = s1_reg;
        prev_next = s2_reg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_reg   <= 1'b0;
            s2_reg   <= 1'b0;
            prev_reg <= 1'b0;
        end
        else
        begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            prev_reg <= prev_next;
        end
    end

    // Edges from consecutive synchronised samples, only while on
    assign ch.rise_evt = ch.chan_on & s2_reg & ~prev_reg;
    assign ch.fall_evt = ch.chan_on & ~s2_reg & prev_reg;

    // Latched output is the synchronised value, low while off
    assign ch.latched  = ch.chan_on & s2_reg;

    // Raw path needs no clock, so it keeps working in stop states
    assign ch.raw_out  = ch.chan_on & ch.cmp_in;

    // Wake the oscillator while on and the result is low
    assign ch.wake     = ch.chan_on & ~ch.cmp_in;
endmodule

// File: test/dcc_checker.sv
// Concurrent assertions on the ports of the comparator control block
`timescale 1ns/1ps
module dcc_checker
(
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic                  cmp_result_a,
    input wire logic                  cmp_result_b,
    input wire logic                  chan_on,
    input wire logic                  chan_b_on,
    input wire logic                  raw_out_a,
    input wire logic                  latched_out_a,
    input wire logic                  reset_src_a,
    input wire logic                  wake_req,
    input wire dcc_pkg::dcc_resp_type response_mode_sel
);
    import dcc_pkg::*;
    // ********************
    // Port relations
    // ********************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_off; !chan_on |-> !raw_out_a && !latched_out_a; endproperty
    a_off: assert property (p_off) else $error("output high while off");
    property p_raw; chan_on |-> raw_out_a == cmp_result_a; endproperty
    a_raw: assert property (p_raw) else $error("raw output wrong");
    // Two flops between raw input and latched output
    property p_sync;
        chan_on && $past(chan_on) && $past(chan_on, 2) |-> latched_out_a == $past(cmp_result_a, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("latched output lag wrong");
    property p_wake;
        wake_req == (chan_on && !cmp_result_a || chan_b_on && !cmp_result_b);
    endproperty
    a_wake: assert property (p_wake) else $error("wake request wrong");
    property p_rsrc; reset_src_a == latched_out_a; endproperty
    a_rsrc: assert property (p_rsrc) else $error("reset path wrong");
    // Register outputs move only on a write access
    property p_mode; !(psel && penable && pwrite) |=> $stable(response_mode_sel); endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_en; !(psel && penable && pwrite) |=> $stable(chan_on); endproperty
    a_en: assert property (p_en) else $error("enable moved");
    property p_en_b; !(psel && penable && pwrite) |=> $stable(chan_b_on); endproperty
    a_en_b: assert property (p_en_b) else $error("enable b moved");
    c_rise: cover property ($rose(latched_out_a));
    c_fall: cover property ($fell(latched_out_a));
    c_wake: cover property ($rose(wake_req));
endmodule

bind dcc_top dcc_checker i_dcc_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .cmp_result_a, .cmp_result_b, .chan_on, .chan_b_on, .raw_out_a, .latched_out_a,
    .reset_src_a, .wake_req, .response_mode_sel);

// File: test/dual_comparator_control_tb.sv
// Self-checking testbench of the dual comparator control block
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dual_comparator_control_tb;
    import dcc_pkg::*;
    logic            pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic            cmp_result_a = 0, cmp_result_b = 0;
    logic [11:0]     paddr = 0;
    logic [31:0]     pwdata = 0, prdata;
    logic [3:0]      pstrb = 4'hf;
    logic            pready, pslverr, chan_on, chan_b_on, raw_out_a, raw_out_b, irq;
    logic            latched_out_a, latched_out_b, reset_src_a, edge_irq_a, edge_irq_b, wake_req;
    dcc_hyst_type    pos_hyst_code, neg_hyst_code, pos_hyst_code_b, neg_hyst_code_b;
    dcc_resp_type    response_mode_sel, response_mode_sel_b;
    dcc_pin_sel_type pos_pin_sel_a, neg_pin_sel_a, pos_pin_sel_b, neg_pin_sel_b;
    logic [7:0]      mdl [9] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    int              miscompares = 0, n_checks = 0, cyc = 0;

    dcc_top i_dcc_top (.*);

    // ********************
    // Clock, checks and bus
    // ********************
    always #12.5 pclk = ~pclk;

    // Cycle limit cuts a hang short
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [39:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // Model update on a register write; status is write one to clear
    function automatic void mdl_wr(int i, logic [7:0] d);
        case (i)
            0, 1: mdl[i] = (d & 8'hbf) | (d[7] ? mdl[i] & 8'h40 : 8'h00);
            2, 3: mdl[i] = d & 8'h33;
            6: mdl[i] = mdl[i] & ~d & 8'h0f;
            7: mdl[i] = d & 8'h0f;
            default: mdl[i] = d;
        endcase
    endfunction

    // One APB transfer to slot i; slot 8 is unmapped
    task automatic xfer(int i, logic w, logic [7:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'h0, 8'(`DCC_IDX_CTRL_B + i), 2'h0};
        pwdata <= {24'($urandom), d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        chk("resp", {pslverr, w ? 32'h0 : prdata},
            {i == 8, 24'h0, w ? 8'h0 : mdl[i]});
        // A write with byte lane 0 off is dropped without an error
        if (w && i < 8 && pstrb[0])
            mdl_wr(i, d);
        psel <= 0;
        penable <= 0;
    endtask

    // Compare all status outputs with the model once settled
    task automatic chk_out();
        logic [7:0] a, b;
        @(negedge pclk);
        a = mdl[1];
        b = mdl[0];
        chk("on", {chan_on, chan_b_on}, {a[7], b[7]});
        chk("raw", {raw_out_a, raw_out_b}, {a[7] & cmp_result_a, b[7] & cmp_result_b});
        chk("lat", {latched_out_a, latched_out_b, reset_src_a}, {a[6], b[6], a[6]});
        chk("hys", {pos_hyst_code, neg_hyst_code, pos_hyst_code_b, neg_hyst_code_b},
            {a[3:0], b[3:0]});
        chk("md", {response_mode_sel, response_mode_sel_b},
            {mdl[3][1:0], mdl[2][1:0]});
        chk("pin", {neg_pin_sel_a, pos_pin_sel_a, neg_pin_sel_b, pos_pin_sel_b},
            {mdl[5], mdl[4]});
        chk("eirq", {edge_irq_a, edge_irq_b},
            {|(a[5:4] & mdl[3][5:4]), |(b[5:4] & mdl[2][5:4])});
        chk("wake", wake_req, a[7] & !cmp_result_a | b[7] & !cmp_result_b);
        chk("irq", irq, |(mdl[6] & mdl[7]));
    endtask

    // Drive one comparator input, wait out the synchroniser, update the model
    task automatic set_cmp(int ch, logic v);
        int c;
        c = 1 - ch;
        @(posedge pclk);
        if (ch == 0)
            cmp_result_a <= v;
        else
            cmp_result_b <= v;
        repeat (4) @(posedge pclk);
        if (mdl[c][7] && mdl[c][6] != v)
        begin
            mdl[c][6] = v;
            mdl[c][v ? 5 : 4] = 1;
            if (mdl[c + 2][v ? 5 : 4])
                mdl[6][2 * ch + !v] = 1;
        end
        chk_out();
    endtask

    // Reset values, random register traffic, hysteresis codes, then edges
    initial
    begin
        void'($urandom(50495));
        repeat (4) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 9; i++)
            xfer(i, 0, 0);
        for (int n = 0; n < 27; n++)
        begin
            xfer(n % 9, 1, 8'($urandom & 8'h7f));
            xfer(n % 9, 0, 0);
            // Random lanes for the next write; all lanes on again after the last
            pstrb <= (n < 26) ? 4'($urandom) : 4'hf;
            chk_out();
        end
        for (int k = 0; k < 4; k++)
        begin
            xfer(0, 1, 8'(k * 5));
            xfer(1, 1, 8'(k * 5));
            xfer(3, 1, 8'(k));
            chk_out();
        end
        for (int ch = 0; ch < 2; ch++)
        begin
            xfer(1 - ch, 1, 8'h80);
            xfer(3 - ch, 1, ch ? 8'h20 : 8'h30);
            xfer(7, 1, 8'h0f);
            set_cmp(ch, 1);
            set_cmp(ch, 0);
            xfer(1 - ch, 0, 0);
            xfer(6, 0, 0);
            xfer(6, 1, 8'h0f);
            xfer(1 - ch, 1, 8'h80);
            xfer(7, 1, 8'h00);
            set_cmp(ch, 1);
            xfer(1 - ch, 1, 8'h00);
            set_cmp(ch, 0);
            xfer(1 - ch, 0, 0);
            xfer(6, 0, 0);
        end
        stop_test();
    end
endmodule
